// ### core/tlic_consts.svh
// Purpose: constants of the two-level interrupt controller
// Assumes: included by the controller and by bench code
// Notes:   offsets are word indices on the plain register port
`ifndef TLIC_CONSTS_SVH
`define TLIC_CONSTS_SVH

// register indices
`define TLIC_ADDR_MAIN   2'h0
`define TLIC_ADDR_EDGE   2'h1
`define TLIC_ADDR_MODE   2'h2
`define TLIC_ADDR_STAT   2'h3

// reset values
`define TLIC_RST_MAIN    8'h00
`define TLIC_RST_EDGE    8'hf5
`define TLIC_RST_MODE    1'b0

// implemented bits of the edge/priority register
`define TLIC_EDGE_MASK   8'hf5

// bit position of the mode bit in its register
`define TLIC_MODE_BIT    7

// vector addresses
`define TLIC_VEC_HIGH    24'h000008
`define TLIC_VEC_LOW     24'h000018

// core clocks in one instruction cycle
`define TLIC_CLKS_PER_INSTR 4

`endif

// ### core/tlic_pkg.sv
// Purpose: types of the two-level interrupt controller
// Assumes: nothing beyond the constants header
// Notes:   field order matches register bit order, msb first
package tlic_pkg;

  typedef logic [1:0]  tlic_addr_t;   // register index
  typedef logic [7:0]  tlic_byte_t;   // register data
  typedef logic [23:0] tlic_vec_t;    // program address

  // main control register, bit 7 down to bit 0
  typedef struct packed {
    logic gie_high;         // global / high-level enable
    logic gie_low_periph;   // peripheral / low-level enable
    logic timer_zero_en;
    logic int0_en;
    logic port_en;
    logic timer_zero_flag;
    logic int0_flag;
    logic port_flag;
  } tlic_main_t;

  // edge select and priority register, bit 7 down to bit 0
  typedef struct packed {
    logic pullup_dis;
    logic edge0;
    logic edge1;
    logic edge2;
    logic rsv3;
    logic timer_zero_prio;
    logic rsv1;
    logic port_prio;
  } tlic_edge_t;

  // service level, one-hot
  typedef enum logic [3:0] {
    SVC_NONE      = 4'b0001,
    SVC_LOW       = 4'b0010,
    SVC_HIGH      = 4'b0100,
    SVC_HIGH_LOW  = 4'b1000
  } tlic_svc_t;

endpackage

// ### core/tlic_top.sv
// Purpose: two-level interrupt controller for an 8-bit core
// Assumes: single clock clk_sys, synchronous active-low reset
// Notes:   the core acknowledges a request and reports return
//
// Notes on behaviour
// - high vector 000008h, low vector 000018h
// - high request preempts running low routine
// - each source has flag, enable, priority, except pin zero (no priority bit, always high)
// - mode bit set: bit 7 enables high sources
// - two-level: bit 6 enables low sources
// - flag, enable, global enable vector immediately
// - default mode: bit 6 peripheral, bit 7 global
// - compatibility: priorities ignored, vector 000008h
// - response clears the applicable global enable
// - low requests held off during high routine
// - vectoring pushes return address, loads vector
// - return instruction sets applicable enable again
// - pin events serviced within three-four instructions
// - flags set regardless of any enable
// - enables bits 5-3, flags bits 2-0
// - timer and pin-zero flags sticky until cleared
// - upper port nibble change sets sticky flag
// - bits 6-4 select edges, 1 rising
// - bit 2 timer priority, bit 0 port priority
// - bit 7 disables pull-ups, else latch
`timescale 1ns/100ps
`include "tlic_consts.svh"
`default_nettype none

module tlic_top #(
  parameter int CLKS_PER_INSTR = `TLIC_CLKS_PER_INSTR  // clocks per instruction cycle
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire tlic_pkg::tlic_addr_t reg_addr,
  input  wire tlic_pkg::tlic_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  tlic_pkg::tlic_byte_t reg_rdata,
  input  wire logic               timer_zero_overflow,
  input  wire logic [2:0]         ext_pin,
  input  wire logic [3:0]         port_pins,
  input  wire logic [7:0]         port_latch,
  input  wire logic               periph_pending,
  input  wire logic               periph_priority,
  input  wire logic               irq_ack,
  input  wire logic               return_from_irq,
  output logic                    irq_request,
  output var  tlic_pkg::tlic_vec_t irq_vector,
  output logic                    stack_push,
  output logic                    pc_load,
  output logic [7:0]              pullup_en,
  output logic                    ext_pin_one_event,
  output logic                    ext_pin_two_event
);
  import tlic_pkg::*;

  localparam int CW = (CLKS_PER_INSTR > 1) ? $clog2(CLKS_PER_INSTR) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(CLKS_PER_INSTR - 1);

  tlic_main_t       main_reg;      // enables and flags
  tlic_edge_t       edge_reg;      // edge selects, priorities, pull-ups
  logic             mode_reg;      // priority_mode_enable
  tlic_svc_t        svc_reg;       // service level in progress
  logic [CW-1:0]    instr_cnt_reg; // instruction cycle divider
  logic             instr_tick;    // one pulse per instruction cycle
  logic [6:0]       sync1_reg;     // first sync stage, read by stage two only
  logic [6:0]       sync2_reg;     // synchronised pin levels
  logic [6:0]       prev_reg;      // previous synchronised levels
  logic [2:0]       ext_edge;      // qualifying edge per external pin
  logic             port_change;   // any upper port pin changed
  logic             wr_main;       // software write to main register
  logic             high_pend;     // enabled high-level source pending
  logic             low_pend;      // enabled low-level source pending
  logic             any_pend;      // enabled source pending, any level
  logic             hi_req;        // qualified high request
  logic             lo_req;        // qualified low request
  logic             req_high_reg;  // posted request is high level
  logic             ack_take;      // core accepted the posted request
  tlic_byte_t       rdata_next;    // read mux

  // instruction cycle divider; requests are posted on its tick so the
  // latency does not depend on the length of the running instruction
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      instr_cnt_reg <= '0;
    end else if (instr_cnt_reg == CNT_LAST) begin
      instr_cnt_reg <= '0;
    end else begin
      instr_cnt_reg <= instr_cnt_reg + CW'(1);
    end
  end

  assign instr_tick = (instr_cnt_reg == CNT_LAST);

  // two-stage synchroniser for external and port pins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      prev_reg  <= 7'h00;
    end else begin
      sync1_reg <= {port_pins, ext_pin};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // edge selection per pin; 1 picks rising, 0 falling
  always_comb begin
    ext_edge[0] = edge_reg.edge0 ? (sync2_reg[0] & ~prev_reg[0]) : (~sync2_reg[0] & prev_reg[0]);
    ext_edge[1] = edge_reg.edge1 ? (sync2_reg[1] & ~prev_reg[1]) : (~sync2_reg[1] & prev_reg[1]);
    ext_edge[2] = edge_reg.edge2 ? (sync2_reg[2] & ~prev_reg[2]) : (~sync2_reg[2] & prev_reg[2]);
  end

  // change on any of the upper four port pins; the reset levels are
  // zero, so a pin held high at reset release reports one change
  assign port_change = |(sync2_reg[6:3] ^ prev_reg[6:3]);

  assign wr_main  = reg_wr && (reg_addr == `TLIC_ADDR_MAIN);
  assign ack_take = irq_ack && irq_request;

  // pending sources per level; pin zero has no priority bit and is
  // always a high-level source
  always_comb begin
    high_pend = (main_reg.int0_en & main_reg.int0_flag)
              | (main_reg.timer_zero_en & main_reg.timer_zero_flag & edge_reg.timer_zero_prio)
              | (main_reg.port_en & main_reg.port_flag & edge_reg.port_prio)
              | (periph_pending & periph_priority);
    low_pend  = (main_reg.timer_zero_en & main_reg.timer_zero_flag & ~edge_reg.timer_zero_prio)
              | (main_reg.port_en & main_reg.port_flag & ~edge_reg.port_prio)
              | (periph_pending & ~periph_priority);
    any_pend  = (main_reg.int0_en & main_reg.int0_flag)
              | (main_reg.timer_zero_en & main_reg.timer_zero_flag)
              | (main_reg.port_en & main_reg.port_flag)
              | (periph_pending & main_reg.gie_low_periph);
  end

  // request qualification by mode and global enables
  always_comb begin
    if (mode_reg) begin
      hi_req = main_reg.gie_high & high_pend;
      lo_req = main_reg.gie_low_periph & low_pend & ~hi_req
             & (svc_reg == SVC_NONE);
    end else begin
      hi_req = main_reg.gie_high & any_pend;
      lo_req = 1'b0;
    end
  end

  // posted request to the core; re-evaluated every instruction cycle
  // and withdrawn at once if its qualification disappears
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_request  <= 1'b0;
      irq_vector   <= `TLIC_VEC_HIGH;
      req_high_reg <= 1'b0;
    end else if (ack_take) begin
      irq_request <= 1'b0;
    end else if (instr_tick) begin
      irq_request  <= hi_req | lo_req;
      req_high_reg <= hi_req;
      irq_vector   <= (hi_req || !mode_reg) ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW;
    end else if (!(hi_req || lo_req)) begin
      irq_request <= 1'b0;
    end
  end

  // strobes to the program sequencer on acceptance
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stack_push <= 1'b0;
      pc_load    <= 1'b0;
    end else begin
      stack_push <= ack_take;
      pc_load    <= ack_take;
    end
  end

  // service level tracking; a high routine may nest over a low one
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      svc_reg <= SVC_NONE;
    end else if (ack_take) begin
      if (!mode_reg || req_high_reg) begin
        svc_reg <= (svc_reg == SVC_LOW) ? SVC_HIGH_LOW : SVC_HIGH;
      end else begin
        svc_reg <= SVC_LOW;
      end
    end else if (return_from_irq) begin
      unique case (svc_reg)
        SVC_HIGH_LOW: svc_reg <= SVC_LOW;
        SVC_HIGH:     svc_reg <= SVC_NONE;
        SVC_LOW:      svc_reg <= SVC_NONE;
        SVC_NONE:     svc_reg <= SVC_NONE;
      endcase
    end
  end

  // main control register; hardware flag sets win over a software
  // clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      main_reg <= `TLIC_RST_MAIN;
    end else begin
      if (wr_main) begin
        main_reg.gie_high       <= reg_wdata[7];
        main_reg.gie_low_periph <= reg_wdata[6];
        main_reg.timer_zero_en        <= reg_wdata[5];
        main_reg.int0_en        <= reg_wdata[4];
        main_reg.port_en        <= reg_wdata[3];
      end
      // response clears the enable, return sets it; hardware wins
      if (ack_take) begin
        if (!mode_reg || req_high_reg) begin
          main_reg.gie_high <= 1'b0;
        end else begin
          main_reg.gie_low_periph <= 1'b0;
        end
      end else if (return_from_irq) begin
        if (mode_reg && (svc_reg == SVC_LOW)) begin
          main_reg.gie_low_periph <= 1'b1;
        end else begin
          main_reg.gie_high <= 1'b1;
        end
      end
      // flags ignore every enable
      main_reg.timer_zero_flag <= timer_zero_overflow | (wr_main ? reg_wdata[2] : main_reg.timer_zero_flag);
      main_reg.int0_flag <= ext_edge[0] | (wr_main ? reg_wdata[1] : main_reg.int0_flag);
      main_reg.port_flag <= port_change | (wr_main ? reg_wdata[0] : main_reg.port_flag);
    end
  end

  // edge, priority and pull-up register; reserved bits stay zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      edge_reg <= `TLIC_RST_EDGE;
    end else if (reg_wr && (reg_addr == `TLIC_ADDR_EDGE)) begin
      edge_reg <= reg_wdata & `TLIC_EDGE_MASK;
    end
  end

  // priority mode bit; cleared at reset gives compatibility mode
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_reg <= `TLIC_RST_MODE;
    end else if (reg_wr && (reg_addr == `TLIC_ADDR_MODE)) begin
      mode_reg <= reg_wdata[`TLIC_MODE_BIT];
    end
  end

  // pin events for the sources whose flags live elsewhere
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ext_pin_one_event <= 1'b0;
      ext_pin_two_event <= 1'b0;
    end else begin
      ext_pin_one_event <= ext_edge[1];
      ext_pin_two_event <= ext_edge[2];
    end
  end

  // pull-ups follow the latch unless globally disabled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pullup_en <= 8'h00;
    end else begin
      pullup_en <= edge_reg.pullup_dis ? 8'h00 : port_latch;
    end
  end

  // read mux; status shows the service level one-hot
  always_comb begin
    case (reg_addr)
      `TLIC_ADDR_MAIN: rdata_next = main_reg;
      `TLIC_ADDR_EDGE: rdata_next = edge_reg;
      `TLIC_ADDR_MODE: rdata_next = {mode_reg, 7'h00};
      default:         rdata_next = {4'h0, svc_reg};
    endcase
  end

  // read data stand the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model answers requests and returns on command
// Notes:   expectations worked out step by step from register layout
`timescale 1ns/100ps
`include "tlic_consts.svh"
`default_nettype none
module tb_top;
  import tlic_pkg::*;
  logic       clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, timer_zero_overflow = 0;
  logic       periph_pending = 0, periph_priority = 0, irq_ack, return_from_irq;
  logic       irq_request, stack_push, pc_load, ext_pin_one_event, ext_pin_two_event;
  tlic_addr_t reg_addr = 0;
  tlic_byte_t reg_wdata = 0, reg_rdata;
  logic [2:0] ext_pin = 0;
  logic [3:0] port_pins = 0, ack_wait = 0;
  logic [7:0] port_latch = 0, pullup_en;
  tlic_vec_t  irq_vector;
  int         mismatches = 0, comparisons = 0, n, s, ev1 = 0, ev2 = 0;
  tlic_byte_t rst_val[4] = '{`TLIC_RST_MAIN, `TLIC_RST_EDGE, 8'h00, 8'h01};
  tlic_top #(.CLKS_PER_INSTR(4)) i_tlic_top (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_zero_overflow, .ext_pin, .port_pins, .port_latch, .periph_pending,
    .periph_priority, .irq_ack, .return_from_irq, .irq_request, .irq_vector, .stack_push,
    .pc_load, .pullup_en, .ext_pin_one_event, .ext_pin_two_event);
  tlic_core_model i_tlic_core_model (.clk_sys, .nrst, .irq_request, .irq_vector, .ack_wait,
    .irq_ack, .return_from_irq);
  always #5 clk_sys = ~clk_sys;
  // count secondary pin events; cleared off-edge by the sequence
  always @(posedge clk_sys) begin
    if (ext_pin_one_event === 1'b1) ev1++;
    if (ext_pin_two_event === 1'b1) ev2++;
  end
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // single-byte writes only, never block moves into live control bits
  task automatic wr(tlic_addr_t a, tlic_byte_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(tlic_addr_t a, tlic_byte_t e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, e);
  endtask
  task automatic tmr_pulse;
    @(posedge clk_sys);
    timer_zero_overflow <= 1'b1;
    @(posedge clk_sys);
    timer_zero_overflow <= 1'b0;
  endtask
  // bounded wait; a missing push then shows as an empty vector queue
  task automatic wait_push;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (stack_push !== 1'b1 && n < 40);
  endtask
  // watchdog: the sequence needs under 300 cycles
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    s = $urandom(43888);
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(tlic_addr_t'(i), rst_val[i]);
    s = $urandom;
    wr(1, s[7:0]);
    rdc(1, s[7:0] & `TLIC_EDGE_MASK);
    wr(3, 8'hff);
    rdc(3, 8'h01);
    wr(2, 8'hff);
    rdc(2, 8'h80);
    wr(2, 8'h00);
    port_latch <= 8'($urandom);
    wr(1, 8'h75);
    cyc(2);
    chk("pullup", pullup_en, port_latch);
    wr(1, 8'hf5);
    // flags set with every enable off, and stay set
    tmr_pulse();
    port_pins <= 4'($urandom_range(15, 1));
    ext_pin[0] <= 1'b1;
    cyc(10);
    chk("req", irq_request, 1'b0);
    rdc(0, 8'h07);
    wr(0, 8'h00);
    ext_pin[0] <= 1'b0;
    cyc(10);
    rdc(0, 8'h00);
    // secondary pins: falling, then rising selection
    for (s = 0; s < 2; s++) begin
      wr(1, s ? 8'hf5 : 8'hc5);
      cyc(1);
      ev1 = 0;
      ev2 = 0;
      @(posedge clk_sys);
      ext_pin[2:1] <= 2'b11;
      cyc(10);
      chk("ev_rise", ev1 * 2 + ev2, s * 3);
      @(posedge clk_sys);
      ext_pin[2:1] <= 2'b00;
      cyc(10);
      chk("ev_all", ev1 * 2 + ev2, 3);
    end
    // compatibility mode with a slow core
    @(posedge clk_sys);
    ack_wait <= 4'($urandom_range(7, 0));
    wr(0, 8'ha0);
    tmr_pulse();
    wait_push();
    chk("vec", i_tlic_core_model.vq.pop_front(), `TLIC_VEC_HIGH);
    rdc(0, 8'h24);
    wr(0, 8'h20);
    i_tlic_core_model.do_return();
    rdc(0, 8'ha0);
    @(posedge clk_sys);
    periph_pending <= 1'b1;
    periph_priority <= 1'($urandom);
    wr(0, 8'h80);
    cyc(12);
    chk("req", irq_request, 1'b0);
    wr(0, 8'hc0);
    wait_push();
    chk("vec", i_tlic_core_model.vq.pop_front(), `TLIC_VEC_HIGH);
    @(posedge clk_sys);
    periph_pending <= 1'b0;
    wr(0, 8'h00);
    i_tlic_core_model.do_return();
    // two-level mode: timer low, port change high
    ack_wait <= 4'h0;
    wr(2, 8'h80);
    wr(1, 8'hf1);
    wr(0, 8'he8);
    tmr_pulse();
    wait_push();
    chk("vec", i_tlic_core_model.vq.pop_front(), `TLIC_VEC_LOW);
    rdc(3, 8'h02);
    rdc(0, 8'hac);
    @(posedge clk_sys);
    port_pins <= ~port_pins;
    wait_push();
    chk("latency", n <= 16, 1'b1);
    chk("vec", i_tlic_core_model.vq.pop_front(), `TLIC_VEC_HIGH);
    rdc(3, 8'h08);
    rdc(0, 8'h2d);
    wr(0, 8'h6c);
    cyc(12);
    chk("req", irq_request, 1'b0);
    i_tlic_core_model.do_return();
    rdc(3, 8'h02);
    rdc(0, 8'hec);
    i_tlic_core_model.do_return();
    wait_push();
    chk("vec", i_tlic_core_model.vq.pop_front(), `TLIC_VEC_LOW);
    wr(0, 8'h00);
    i_tlic_core_model.do_return();
    rdc(3, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### sim/tlic_core_model.sv
// Purpose: core-side partner: takes requests, records vectors, returns
// Assumes: hand-over timing of request, ack and return
// Notes:   ack delay from the bench; returns commanded by task
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                irq_request,
  input  wire tlic_pkg::tlic_vec_t irq_vector,
  input  wire logic [3:0]          ack_wait,
  output var  logic                irq_ack,
  output var  logic                return_from_irq
);
  import tlic_pkg::*;
  int        wait_cnt = 0;  // cycles the request stood unanswered
  tlic_vec_t vq[$];         // vectors taken, oldest first
  // quiet at time zero, before the first edge
  initial begin
    irq_ack = 1'b0;
    return_from_irq = 1'b0;
  end
  // ack only a standing request; a slow core is legal, so wait is settable
  always @(posedge clk_sys) begin
    irq_ack <= 1'b0;
    if (irq_ack && irq_request) vq.push_back(irq_vector);
    if (!nrst || !irq_request || irq_ack) wait_cnt <= 0;
    else if (wait_cnt >= ack_wait) irq_ack <= 1'b1;
    else wait_cnt <= wait_cnt + 1;
  end
  // return instruction, one pulse; a flag the caller leaves set requests again
  task automatic do_return;
    @(posedge clk_sys);
    return_from_irq <= 1'b1;
    @(posedge clk_sys);
    return_from_irq <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/tlic_sva.sv
// Purpose: port checker for the two-level interrupt controller
// Assumes: one clock, synchronous active-low reset
// Notes:   shadows track bits that only software writes
`timescale 1ns/100ps
`default_nettype none
module tlic_chk (
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire tlic_pkg::tlic_addr_t reg_addr,
  input wire tlic_pkg::tlic_byte_t reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire tlic_pkg::tlic_byte_t reg_rdata,
  input wire logic [7:0]           port_latch,
  input wire logic                 irq_ack,
  input wire logic                 irq_request,
  input wire tlic_pkg::tlic_vec_t  irq_vector,
  input wire logic                 stack_push,
  input wire logic                 pc_load,
  input wire logic [7:0]           pullup_en
);
  import tlic_pkg::*;
  logic pud_reg;    // pull-up disable as last written
  logic pmode_reg;  // priority mode as last written
  // shadow writes; no hardware path touches these bits, so a copy is exact
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pud_reg   <= 1'b1;
      pmode_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 2'h1) pud_reg <= reg_wdata[7];
      if (reg_addr == 2'h2) pmode_reg <= reg_wdata[7];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // core takes a standing request
  sequence s_accept;
    irq_ack && irq_request;
  endsequence
  a_ack_push_pc: assert property (s_accept |=> stack_push && pc_load)
    else $error("no push after ack");
  a_push_has_ack: assert property (stack_push |-> $past(irq_ack) && $past(irq_request))
    else $error("push without ack");
  a_ack_drops_req: assert property (s_accept |=> !irq_request)
    else $error("request stands after ack");
  a_vector_legal: assert property (irq_request |-> irq_vector inside {24'h000008, 24'h000018})
    else $error("bad vector");
  a_compat_vector: assert property (!pmode_reg && irq_request |-> irq_vector == 24'h000008)
    else $error("compat vector wrong");
  a_pullup_follow: assert property (pullup_en == ($past(pud_reg) ? 8'h00 : $past(port_latch)))
    else $error("pull-ups wrong");
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_mode_readback: assert property ($past(reg_rd) && $past(reg_addr) == 2'h2 |-> reg_rdata == {$past(pmode_reg), 7'h00})
    else $error("mode read wrong");
  a_edge_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 2'h1 |->
    reg_rdata[7] == $past(pud_reg) && reg_rdata[3] == 1'b0 && reg_rdata[1] == 1'b0)
    else $error("edge register read wrong");
endmodule
bind tlic_top tlic_chk i_tlic_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .port_latch, .irq_ack, .irq_request, .irq_vector, .stack_push, .pc_load, .pullup_en);
`default_nettype wire
